// ===== rtl/mfc_pkg.sv
// Shared constants and state types of the multi-I/O flash controller
package mfc_pkg;

    // ********************************************************
    // Mapped read window and modes
    // ********************************************************
    localparam logic [31:0] MAP_BASE       = 32'h1800_0000;
    localparam logic [31:0] MAP_LAST       = 32'h1bff_ffff;
    localparam int          MAP_OFS_W      = 26;
    localparam logic        MODE_MAPPED    = 1'b0;
    localparam logic        MODE_SW        = 1'b1;

    // ********************************************************
    // Mapped read transaction shape
    // ********************************************************
    localparam logic [7:0]  MAP_OPCODE     = 8'h0c;
    localparam logic [2:0]  MAP_ADDR_BYTES = 3'h4;
    localparam logic [2:0]  MAP_DATA_BYTES = 3'h4;
    localparam logic [4:0]  MAP_DUMMY      = 5'h08;

    // ********************************************************
    // Link timing and pin drive
    // ********************************************************
    localparam logic [5:0]  OPCODE_BITS    = 6'h08;
    localparam logic [5:0]  DESEL_PERIODS  = 6'h02;
    localparam logic [1:0]  PH_LAST        = 2'h3;
    localparam logic [3:0]  OE_NONE        = 4'h0;
    localparam logic [3:0]  OE_SINGLE      = 4'h1;
    localparam logic [3:0]  OE_QUAD        = 4'hf;
    localparam logic [31:0] WORD_RST       = 32'h0000_0000;

    typedef enum logic [5:0] {
        ENG_IDLE  = 6'h01,
        ENG_CMD   = 6'h02,
        ENG_ADDR  = 6'h04,
        ENG_DUMMY = 6'h08,
        ENG_DATA  = 6'h10,
        ENG_DESEL = 6'h20
    } mfc_eng_e;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_MAP  = 4'h2,
        ST_SW   = 4'h4,
        ST_ACK  = 4'h8
    } mfc_ctl_e;

endpackage : mfc_pkg

// ===== rtl/mfc_link_engine.sv
// Serial link engine on the link clock: opcode, address, dummy and data phases
`timescale 1ns/1ns
`default_nettype none

module mfc_link_engine
    import mfc_pkg::*;
(
    input  wire logic        link_clk,
    input  wire logic        rst_b,
    input  wire logic        req_tgl,
    input  wire logic [7:0]  d_opcode,
    input  wire logic [31:0] d_addr,
    input  wire logic [2:0]  d_addr_bytes,
    input  wire logic [4:0]  d_dummy,
    input  wire logic        d_read,
    input  wire logic [2:0]  d_data_bytes,
    input  wire logic [31:0] d_wdata,
    input  wire logic        d_quad,
    input  wire logic        d_chip,
    output logic             done_tgl_q,
    output logic [31:0]      rdata_q,
    output logic             link_clock_out,
    output logic             link_select_out_b,
    output logic             link_select2_out_b,
    input  wire logic [3:0]  link_io_in,
    output logic [3:0]       link_io_out,
    output logic [3:0]       link_io_oe
);

    // ********************************************************
    // Reset release and input synchronisers
    // ********************************************************
    logic [1:0] rs_q;
    logic       req_s1_q, req_s2_q, req_s3_q;
    logic [3:0] io_s1_q, io_s2_q;
    wire        lrst_b = rs_q[1];

    always_ff @(posedge link_clk or negedge rst_b)
    begin
        if (!rst_b) rs_q <= 2'h0;
        else        rs_q <= {rs_q[0], 1'b1};
    end

    always_ff @(posedge link_clk or negedge lrst_b)
    begin
        if (!lrst_b)
        begin
            {req_s1_q, req_s2_q, req_s3_q} <= 3'h0;
            io_s1_q <= 4'h0;
            io_s2_q <= 4'h0;
        end
        else
        begin
            {req_s1_q, req_s2_q, req_s3_q} <= {req_tgl, req_s1_q, req_s2_q};
            io_s1_q <= link_io_in;
            io_s2_q <= io_s1_q;
        end
    end

    // ********************************************************
    // Phase sequencing
    // ********************************************************
    mfc_eng_e    st_q, st_d;
    logic [1:0]  ph_q, ph_d;
    logic [5:0]  cnt_q, cnt_d;
    logic [31:0] sh_q, sh_d;

    wire         start    = req_s2_q ^ req_s3_q;
    wire         bit_end  = (st_q != ENG_IDLE) && (ph_q == PH_LAST);
    wire         last_bit = bit_end && (cnt_q == 6'h01);
    wire         quad_now = d_quad && (st_q == ENG_DATA);
    wire [5:0]   addr_cnt = {d_addr_bytes, 3'h0};
    wire [5:0]   data_cnt = d_quad ? {2'h0, d_data_bytes, 1'b0} : {d_data_bytes, 3'h0};
    wire [31:0]  addr_al  = d_addr << {3'(3'h4 - d_addr_bytes), 3'h0};
    wire         has_dm   = (d_dummy != 5'h00);
    wire         has_dt   = (data_cnt != 6'h00);
    // Read data from the flash, single wire on line 1 or all four lines
    wire [31:0]  sh_shift = quad_now ? {sh_q[27:0], (d_read ? io_s2_q : 4'h0)}
                                     : {sh_q[30:0], (d_read && st_q == ENG_DATA) & io_s2_q[1]};
    // Next phase after the address, and after the dummy cycles
    wire mfc_eng_e st_ad  = has_dt ? ENG_DATA : ENG_DESEL;
    wire [5:0]   cnt_ad   = has_dt ? data_cnt : DESEL_PERIODS;
    wire mfc_eng_e st_aa  = has_dm ? ENG_DUMMY : st_ad;
    wire [5:0]   cnt_aa   = has_dm ? {1'b0, d_dummy} : cnt_ad;
    wire         sel_d    = (st_d != ENG_IDLE) && (st_d != ENG_DESEL);

    always_comb
    begin
        st_d  = st_q;
        ph_d  = 2'(ph_q + 2'h1);
        cnt_d = bit_end ? 6'(cnt_q - 6'h01) : cnt_q;
        sh_d  = bit_end ? sh_shift : sh_q;
        case (st_q)
            ENG_IDLE:
            begin
                ph_d = 2'h0;
                if (start)
                begin
                    st_d  = ENG_CMD;
                    cnt_d = OPCODE_BITS;
                    sh_d  = {d_opcode, 24'h00_0000};
                end
            end
            ENG_CMD:
                if (last_bit)
                begin
                    st_d  = (addr_cnt != 6'h00) ? ENG_ADDR : st_aa;
                    cnt_d = (addr_cnt != 6'h00) ? addr_cnt : cnt_aa;
                    sh_d  = (addr_cnt != 6'h00) ? addr_al : d_wdata;
                end
            ENG_ADDR:
                if (last_bit)
                begin
                    st_d  = st_aa;
                    cnt_d = cnt_aa;
                    sh_d  = d_wdata;
                end
            ENG_DUMMY:
                if (last_bit)
                begin
                    st_d  = st_ad;
                    cnt_d = cnt_ad;
                    sh_d  = d_wdata;
                end
            ENG_DATA:
                if (last_bit)
                begin
                    st_d  = ENG_DESEL;
                    cnt_d = DESEL_PERIODS;
                end
            ENG_DESEL:
                if (last_bit) st_d = ENG_IDLE;
            default:
            begin
                st_d  = ENG_IDLE;
                ph_d  = 2'h0;
                cnt_d = 6'h00;
            end
        endcase
    end

    // ********************************************************
    // Pin drive and result
    // ********************************************************
    // Lines are released during dummy cycles and read data for turnaround
    wire [3:0] oe_d = (st_d == ENG_CMD || st_d == ENG_ADDR) ? OE_SINGLE :
                      (st_d == ENG_DATA && !d_read) ? (d_quad ? OE_QUAD : OE_SINGLE) :
                      OE_NONE;
    wire [3:0] out_d = (d_quad && st_d == ENG_DATA) ? sh_d[31:28] : {3'h0, sh_d[31]};

    always_ff @(posedge link_clk or negedge lrst_b)
    begin
        if (!lrst_b)
        begin
            st_q               <= ENG_IDLE;
            ph_q               <= 2'h0;
            cnt_q              <= 6'h00;
            sh_q               <= WORD_RST;
            rdata_q            <= WORD_RST;
            done_tgl_q         <= 1'b0;
            link_clock_out     <= 1'b0;
            link_select_out_b  <= 1'b1;
            link_select2_out_b <= 1'b1;
            link_io_out        <= 4'h0;
            link_io_oe         <= OE_NONE;
        end
        else
        begin
            st_q               <= st_d;
            ph_q               <= ph_d;
            cnt_q              <= cnt_d;
            sh_q               <= sh_d;
            link_clock_out     <= sel_d & ph_d[1];
            link_select_out_b  <= !(sel_d && !d_chip);
            link_select2_out_b <= !(sel_d && d_chip);
            link_io_out        <= out_d;
            link_io_oe         <= oe_d;
            if (st_q == ENG_DATA && last_bit && d_read) rdata_q <= sh_d;
            if (st_q == ENG_DESEL && last_bit) done_tgl_q <= !done_tgl_q;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    clk_in_frame_a: assert property (@(posedge link_clk) disable iff (!lrst_b)
        link_clock_out |-> !(link_select_out_b && link_select2_out_b))
        else $error("link clock high with no chip selected");

    start_select_a: assert property (@(posedge link_clk) disable iff (!lrst_b)
        (st_q == ENG_IDLE && start) |=> (st_q == ENG_CMD) ##0
        (!link_select_out_b || !link_select2_out_b) ##0 (link_io_oe == OE_SINGLE))
        else $error("transaction did not open with the opcode phase");

    dummy_release_a: assert property (@(posedge link_clk) disable iff (!lrst_b)
        (st_q == ENG_DUMMY && $past(st_q) == ENG_DUMMY) |-> (link_io_oe == OE_NONE))
        else $error("data lines driven during dummy cycles");

    done_after_desel_a: assert property (@(posedge link_clk) disable iff (!lrst_b)
        $changed(done_tgl_q) |-> ($past(st_q) == ENG_DESEL) && link_select_out_b
        && link_select2_out_b)
        else $error("completion reported while a chip is selected");

endmodule : mfc_link_engine

`default_nettype wire

// ===== rtl/mfc_flash_ctrl.sv
// Top of the multi-I/O flash controller: bus window, software commands, mode
`timescale 1ns/1ns
`default_nettype none

module mfc_flash_ctrl
    import mfc_pkg::*;
#(
    parameter int DUAL_CHIP = 1
)
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        link_clk,
    input  wire logic        mode_select_bit,
    output logic             mode_active,
    // Bus slave
    input  wire logic        bus_valid,
    input  wire logic        bus_write,
    input  wire logic [31:0] bus_addr,
    output logic [31:0]      bus_rdata,
    output logic             bus_ack,
    output logic             bus_err,
    // Software command port
    input  wire logic        sw_start,
    input  wire logic [7:0]  sw_opcode,
    input  wire logic [31:0] sw_addr,
    input  wire logic [2:0]  sw_addr_bytes,
    input  wire logic [4:0]  sw_dummy,
    input  wire logic        sw_read,
    input  wire logic [2:0]  sw_data_bytes,
    input  wire logic [31:0] sw_wdata,
    input  wire logic        sw_quad,
    input  wire logic        sw_chip,
    output logic             sw_busy,
    output logic             sw_done,
    output logic [31:0]      sw_rdata,
    // Flash link
    output logic             link_clock_out,
    output logic             link_select_out_b,
    output logic             link_select2_out_b,
    input  wire logic [3:0]  link_io_in,
    output logic [3:0]       link_io_out,
    output logic [3:0]       link_io_oe
);

    // ********************************************************
    // Request decode
    // ********************************************************
    mfc_ctl_e    st_q;
    logic        mode_q;
    logic        req_tgl_q;
    logic        dn_s1_q, dn_s2_q, dn_s3_q;
    logic [7:0]  d_opcode_q;
    logic [31:0] d_addr_q;
    logic [2:0]  d_addr_bytes_q;
    logic [4:0]  d_dummy_q;
    logic        d_read_q;
    logic [2:0]  d_data_bytes_q;
    logic [31:0] d_wdata_q;
    logic        d_quad_q;
    logic        d_chip_q;
    logic        eng_done_tgl;
    logic [31:0] eng_rdata;

    wire         is_idle  = (st_q == ST_IDLE);
    wire         in_win   = (bus_addr >= MAP_BASE) && (bus_addr <= MAP_LAST);
    // Software start wins over a bus access in the same cycle; the bus
    // master holds its request, so it is served on the next idle cycle.
    wire         take_sw  = is_idle && sw_start && (mode_q == MODE_SW);
    wire         bus_here = is_idle && !take_sw && bus_valid;
    wire         take_map = bus_here && in_win && !bus_write
                            && (mode_q == MODE_MAPPED);
    wire         take_err = bus_here && !take_map;
    wire         done_ev  = dn_s2_q ^ dn_s3_q;
    // Only the window offset reaches the flash, so at most 64 MB is mapped
    wire [31:0]  map_addr = {{(32 - MAP_OFS_W){1'b0}},
                             bus_addr[MAP_OFS_W-1:2], 2'h0};
    wire         chip_sel = sw_chip && (DUAL_CHIP != 0);
    // First flash byte lands in the lowest byte lane of the bus word
    wire [31:0]  map_word = {eng_rdata[7:0], eng_rdata[15:8],
                             eng_rdata[23:16], eng_rdata[31:24]};

    // ********************************************************
    // Control state machine
    // ********************************************************
    mfc_ctl_e st_d;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            ST_IDLE:
                if (take_sw)       st_d = ST_SW;
                else if (take_map) st_d = ST_MAP;
                else if (take_err) st_d = ST_ACK;
            ST_MAP:
                if (done_ev) st_d = ST_ACK;
            ST_SW:
                if (done_ev) st_d = ST_IDLE;
            ST_ACK:
                st_d = ST_IDLE;
            default:
                st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q        <= ST_IDLE;
            mode_q      <= MODE_MAPPED;
            mode_active <= MODE_MAPPED;
        end
        else
        begin
            st_q <= st_d;
            // Idle here means the engine has finished its deselect time
            if (is_idle && !take_sw && !bus_valid)
            begin
                mode_q      <= mode_select_bit;
                mode_active <= mode_select_bit;
            end
        end
    end

    // ********************************************************
    // Descriptor to the link domain
    // ********************************************************
    // Fields stay still from the request toggle until the done toggle
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            req_tgl_q      <= 1'b0;
            d_opcode_q     <= 8'h00;
            d_addr_q       <= WORD_RST;
            d_addr_bytes_q <= 3'h0;
            d_dummy_q      <= 5'h00;
            d_read_q       <= 1'b0;
            d_data_bytes_q <= 3'h0;
            d_wdata_q      <= WORD_RST;
            d_quad_q       <= 1'b0;
            d_chip_q       <= 1'b0;
        end
        else if (take_sw)
        begin
            req_tgl_q      <= !req_tgl_q;
            d_opcode_q     <= sw_opcode;
            d_addr_q       <= sw_addr;
            d_addr_bytes_q <= sw_addr_bytes;
            d_dummy_q      <= sw_dummy;
            d_read_q       <= sw_read;
            d_data_bytes_q <= sw_data_bytes;
            d_wdata_q      <= sw_wdata;
            d_quad_q       <= sw_quad;
            d_chip_q       <= chip_sel;
        end
        else if (take_map)
        begin
            req_tgl_q      <= !req_tgl_q;
            d_opcode_q     <= MAP_OPCODE;
            d_addr_q       <= map_addr;
            d_addr_bytes_q <= MAP_ADDR_BYTES;
            d_dummy_q      <= MAP_DUMMY;
            d_read_q       <= 1'b1;
            d_data_bytes_q <= MAP_DATA_BYTES;
            d_wdata_q      <= WORD_RST;
            d_quad_q       <= 1'b0;
            d_chip_q       <= 1'b0;
        end
    end

    // ********************************************************
    // Answers
    // ********************************************************
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {dn_s1_q, dn_s2_q, dn_s3_q} <= 3'h0;
            bus_rdata <= WORD_RST;
            bus_ack   <= 1'b0;
            bus_err   <= 1'b0;
            sw_busy   <= 1'b0;
            sw_done   <= 1'b0;
            sw_rdata  <= WORD_RST;
        end
        else
        begin
            {dn_s1_q, dn_s2_q, dn_s3_q} <= {eng_done_tgl, dn_s1_q, dn_s2_q};
            bus_ack <= take_err || (st_q == ST_MAP && done_ev);
            bus_err <= take_err;
            sw_done <= (st_q == ST_SW) && done_ev;
            if (take_sw)
                sw_busy <= 1'b1;
            else if (st_q == ST_SW && done_ev)
                sw_busy <= 1'b0;
            if (st_q == ST_MAP && done_ev)
                bus_rdata <= map_word;
            else if (take_err)
                bus_rdata <= WORD_RST;
            if (st_q == ST_SW && done_ev)
                sw_rdata <= eng_rdata;
        end
    end

    // ********************************************************
    // Link engine
    // ********************************************************
    mfc_link_engine u_engine (
        .link_clk           (link_clk),
        .rst_b              (rst_b),
        .req_tgl            (req_tgl_q),
        .d_opcode           (d_opcode_q),
        .d_addr             (d_addr_q),
        .d_addr_bytes       (d_addr_bytes_q),
        .d_dummy            (d_dummy_q),
        .d_read             (d_read_q),
        .d_data_bytes       (d_data_bytes_q),
        .d_wdata            (d_wdata_q),
        .d_quad             (d_quad_q),
        .d_chip             (d_chip_q),
        .done_tgl_q         (eng_done_tgl),
        .rdata_q            (eng_rdata),
        .link_clock_out     (link_clock_out),
        .link_select_out_b  (link_select_out_b),
        .link_select2_out_b (link_select2_out_b),
        .link_io_in         (link_io_in),
        .link_io_out        (link_io_out),
        .link_io_oe         (link_io_oe)
    );

    // ********************************************************
    // Checks
    // ********************************************************
    map_window_a: assert property (@(posedge clk) disable iff (!rst_b)
        take_map |-> (mode_q == MODE_MAPPED) && (bus_addr >= MAP_BASE)
        && (bus_addr <= MAP_LAST) ##1 (st_q == ST_MAP))
        else $error("mapped read taken outside mode 0 or window");

    map_limit_a: assert property (@(posedge clk) disable iff (!rst_b)
        take_map |=> (d_addr_q[31:MAP_OFS_W] == 6'h00)
        && (d_addr_q[MAP_OFS_W-1:2] == $past(bus_addr[MAP_OFS_W-1:2])))
        else $error("mapped read address not limited to the window offset");

    map_shape_a: assert property (@(posedge clk) disable iff (!rst_b)
        (st_q == ST_MAP) |-> (d_opcode_q == MAP_OPCODE) && (d_dummy_q == MAP_DUMMY)
        && (d_addr_bytes_q == MAP_ADDR_BYTES) && d_read_q)
        else $error("mapped read descriptor malformed");

    sw_refuse_a: assert property (@(posedge clk) disable iff (!rst_b)
        (is_idle && bus_valid && !take_sw && mode_q == MODE_SW)
        |=> bus_ack && bus_err ##1 !bus_ack)
        else $error("window access not refused in software mode");

    sw_command_a: assert property (@(posedge clk) disable iff (!rst_b)
        take_sw |=> sw_busy && (d_opcode_q == $past(sw_opcode))
        && (d_wdata_q == $past(sw_wdata)) && (st_q == ST_SW))
        else $error("software command not passed to the link");

    sw_ignored_a: assert property (@(posedge clk) disable iff (!rst_b)
        (is_idle && sw_start && mode_q == MODE_MAPPED) |=> !sw_busy)
        else $error("software command accepted in mapped mode");

    mode_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
        $changed(mode_q) |-> ($past(st_q) == ST_IDLE) && !$past(bus_valid)
        && link_select_out_b && link_select2_out_b)
        else $error("mode changed during a transaction");

    done_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
        sw_done |-> !sw_busy && $past(sw_busy) ##1 !sw_done)
        else $error("software completion pulse malformed");

endmodule : mfc_flash_ctrl

`default_nettype wire

// ===== tb/mfc_flash_model.sv
// Behavioural serial flash: takes opcode, address and data, answers reads
`timescale 1ns/1ns
`default_nettype none

module mfc_flash_model (
    input  wire logic        sck,
    input  wire logic        sel_b,
    input  wire logic        mosi,
    output logic             miso,
    output logic [7:0]       op_q,
    output logic [31:0]      addr_q,
    output logic [31:0]      data_q
);
    int unsigned cnt = 0;
    int unsigned start;
    logic [31:0] ofs;
    logic [7:0]  byte_v;
    logic        talk;

    assign start  = (op_q == 8'h0c) ? 48 : 8;
    assign talk   = (op_q == 8'h0c || op_q == 8'h05) && cnt >= start;
    assign ofs    = addr_q + (cnt - start) / 8;
    assign byte_v = (op_q == 8'h05) ? 8'h3c : ofs[7:0] ^ 8'h5a;
    initial miso = 1'b0;

    // ********************************************************
    // Sample on the rise, drive on the fall
    // ********************************************************
    always @(posedge sck or posedge sel_b)
        if (sel_b)
            cnt <= 0;
        else
        begin
            if (cnt < 8)
                op_q <= {op_q[6:0], mosi};
            else if (cnt < 40)
                addr_q <= {addr_q[30:0], mosi};
            else
                data_q <= {data_q[30:0], mosi};
            cnt <= cnt + 1;
        end

    // Idle line toggles so a stale level never passes for data
    always @(negedge sck or posedge sel_b)
        if (sel_b)
            miso <= ~miso;
        else
            miso <= talk ? byte_v[7 - (cnt - start) % 8] : ~miso;
endmodule : mfc_flash_model
`default_nettype wire

// ===== tb/tb_top.sv
// Bench for the flash controller: mapped reads, refusals, software commands
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %h seen %h", n, e, g); end end

module tb_top;
    import mfc_pkg::*;
    logic clk = 0, link_clk = 0, rst_b = 0, mode = 0, bv = 0, bw = 0, ss = 0, srd = 0;
    logic sq = 0, sch = 0, c1 = 0;
    logic [31:0] ba = 0, sa = 0, swd = 0, qd = 0;
    logic [7:0] sop = 0;
    logic [2:0] sab = 0, sdb = 0;
    logic [4:0] sdm = 0;
    wire logic [31:0] brd, srdat, m_addr, m_data;
    wire logic [7:0] m_op;
    wire logic ack, err, busy, done, sck, s0_b, s1_b, miso, mact;
    wire logic [3:0] io_o, io_oe, io_i;
    int fails = 0, checked = 0, cycles = 0;

    always #20 clk = ~clk;
    initial
    begin
        #3;
        forever #6 link_clk = ~link_clk;
    end
    // Lines 0, 2 and 3 float high when nobody drives them
    assign io_i = {io_oe[3] ? io_o[3] : 1'b1, io_oe[2] ? io_o[2] : 1'b1,
                   io_oe[1] ? io_o[1] : miso, io_oe[0] ? io_o[0] : 1'b1};

    mfc_flash_ctrl i_mfc_flash_ctrl (.clk(clk), .rst_b(rst_b), .link_clk(link_clk),
        .mode_select_bit(mode), .mode_active(mact), .bus_valid(bv), .bus_write(bw),
        .bus_addr(ba), .bus_rdata(brd), .bus_ack(ack), .bus_err(err), .sw_start(ss),
        .sw_opcode(sop), .sw_addr(sa), .sw_addr_bytes(sab), .sw_dummy(sdm), .sw_read(srd),
        .sw_data_bytes(sdb), .sw_wdata(swd), .sw_quad(sq), .sw_chip(sch),
        .sw_busy(busy), .sw_done(done), .sw_rdata(srdat), .link_clock_out(sck),
        .link_select_out_b(s0_b), .link_select2_out_b(s1_b), .link_io_in(io_i),
        .link_io_out(io_o), .link_io_oe(io_oe));
    mfc_flash_model i_mfc_flash_model (.sck(sck), .sel_b(s0_b & s1_b), .mosi(io_i[0]),
        .miso(miso), .op_q(m_op), .addr_q(m_addr), .data_q(m_data));

    // Nibbles seen on all four lines while the controller drives them
    always @(posedge sck)
        if (io_oe == 4'hf) qd <= {qd[27:0], io_o};
    // Chip 0 must stay deselected when the second chip is opened
    always @(negedge s1_b)
        c1 = s0_b;

    task automatic wrap_up();
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    // Hold the request until acknowledged, bounded wait
    task automatic bus_go(input logic [31:0] a, input logic w);
        int n;
        @(negedge clk);
        {ba, bw, bv} = {a, w, 1'b1};
        for (n = 0; n < 400 && ack !== 1'b1; n++) @(negedge clk);
        `CHK("ack", 1'b1, ack)
        bv = 1'b0;
    endtask : bus_go

    task automatic sw_go(input logic [7:0] op, input logic [31:0] a, input logic [2:0] ab,
                         input logic rd, input logic [2:0] db, input logic [31:0] wd);
        int n;
        @(negedge clk);
        {sop, sa, sab, sdm, srd, sdb, swd, ss} = {op, a, ab, 5'h00, rd, db, wd, 1'b1};
        @(negedge clk);
        ss = 1'b0;
        `CHK("busy", 1'b1, busy)
        for (n = 0; n < 400 && done !== 1'b1; n++) @(negedge clk);
        `CHK("done", 1'b1, done)
        `CHK("busy end", 1'b0, busy)
    endtask : sw_go

    task automatic t_map();
        bus_go(MAP_BASE + 32'h10, 1'b0);
        `CHK("err", 1'b0, err)
        `CHK("rdata", 32'h4948_4b4a, brd)
        `CHK("opcode", MAP_OPCODE, m_op)
        `CHK("address", 32'h0000_0010, m_addr)
    endtask : t_map

    task automatic t_edge();
        bus_go(MAP_LAST - 32'h3, 1'b0);
        `CHK("last rdata", 32'ha5a4_a7a6, brd)
        `CHK("last address", 32'h03ff_fffc, m_addr)
        bus_go(MAP_LAST + 32'h1, 1'b0);
        `CHK("outside err", 1'b1, err)
        bus_go(MAP_BASE, 1'b1);
        `CHK("write err", 1'b1, err)
    endtask : t_edge

    task automatic t_sw();
        mode = MODE_SW;
        repeat (3) @(negedge clk);
        `CHK("mode sw", MODE_SW, mact)
        bus_go(MAP_BASE, 1'b0);
        `CHK("window err", 1'b1, err)
        sw_go(8'h12, 32'hfedc_ba98, 3'h4, 1'b0, 3'h2, 32'ha5c3_0000);
        `CHK("prog op", 8'h12, m_op)
        `CHK("prog addr", 32'hfedc_ba98, m_addr)
        `CHK("prog data", 16'ha5c3, m_data[15:0])
        sw_go(8'h21, 32'h0012_3456, 3'h3, 1'b0, 3'h0, 32'h0);
        `CHK("erase addr", 24'h12_3456, m_addr[23:0])
        sw_go(8'h05, 32'h0, 3'h0, 1'b1, 3'h1, 32'h0);
        `CHK("reg op", 8'h05, m_op)
        `CHK("reg rdata", 8'h3c, srdat[7:0])
        {sq, sch} = 2'b10;
        sw_go(8'h32, 32'h0000_0100, 3'h3, 1'b0, 3'h2, 32'h5a3c_0000);
        `CHK("quad data", 16'h5a3c, qd[15:0])
        {sq, sch} = 2'b01;
        sw_go(8'h21, 32'h00ab_cdef, 3'h3, 1'b0, 3'h0, 32'h0);
        {sq, sch} = 2'b00;
        `CHK("chip 1 addr", 24'hab_cdef, m_addr[23:0])
        `CHK("chip 1 alone", 1'b1, c1)
        mode = MODE_MAPPED;
        repeat (3) @(negedge clk);
        `CHK("mode map", MODE_MAPPED, mact)
        `CHK("deselected", 1'b1, s0_b)
    endtask : t_sw

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fails++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        t_map();
        t_edge();
        t_sw();
        t_map();
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
